/* File: design/ptm_pkg.sv */
// Constants for the paired 16/32-bit timer: register map, field positions, resets, prescale counts.
// Assumes a 32-bit classic Wishbone register bus and one 100 MHz clock.
package ptm_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] FIRST_CTRL_OFS = 8'h00;
  localparam logic [7:0] SECOND_CTRL_OFS = 8'h04;
  localparam logic [7:0] FIRST_COUNT_OFS = 8'h08;
  localparam logic [7:0] SECOND_COUNT_OFS = 8'h0C;
  localparam logic [7:0] FIRST_PERIOD_OFS = 8'h10;
  localparam logic [7:0] SECOND_PERIOD_OFS = 8'h14;
  localparam logic [7:0] FLAG_OFS = 8'h18;
  localparam logic [7:0] IRQ_CFG_OFS = 8'h1C;
  // ==========================================================================
  // Control field positions
  localparam int unsigned RUN_BIT = 15;
  localparam int unsigned IDLE_STOP_BIT = 13;
  localparam int unsigned GATE_BIT = 6;
  localparam int unsigned PRESCALE_LSB = 4;
  localparam int unsigned PAIR_BIT = 3;
  localparam int unsigned CLK_SRC_BIT = 1;
  localparam logic [15:0] FIRST_CTRL_MASK = 16'hA07A;
  localparam logic [15:0] SECOND_CTRL_MASK = 16'hA072;
  // Interrupt configuration: enables in bits 1:0, priorities above
  localparam int unsigned FIRST_PRIO_LSB = 4;
  localparam int unsigned SECOND_PRIO_LSB = 8;
  localparam logic [15:0] IRQ_CFG_MASK = 16'h0773;
  // ==========================================================================
  // Reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] IRQ_CFG_RESET = 16'h0000;
  // ==========================================================================
  // Prescaler last count for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PRESCALE_DIV1_LAST = 8'h00;
  localparam logic [7:0] PRESCALE_DIV8_LAST = 8'h07;
  localparam logic [7:0] PRESCALE_DIV64_LAST = 8'h3F;
  localparam logic [7:0] PRESCALE_DIV256_LAST = 8'hFF;
endpackage

/* File: design/ptm_prescale.sv */
// Input clock prescaler for one timer: passes every Nth input tick as a one-cycle pulse.
// Assumes tick_i is a one-cycle enable in the clk_i domain.
`timescale 1ns/10ps
module ptm_prescale (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic clear_i, // Restart the division
  input wire logic tick_i, // Input clock enable
  input wire logic [1:0] sel_i, // Prescale select code
  output logic pulse_o // Divided enable
);
  logic [7:0] cnt_q;
  logic [7:0] last;

  always_comb begin
    unique case (sel_i)
      2'h0: last = ptm_pkg::PRESCALE_DIV1_LAST;
      2'h1: last = ptm_pkg::PRESCALE_DIV8_LAST;
      2'h2: last = ptm_pkg::PRESCALE_DIV64_LAST;
      2'h3: last = ptm_pkg::PRESCALE_DIV256_LAST;
    endcase
  end

  // Compare with >= so a ratio cut on the fly cannot strand the count
  assign pulse_o = tick_i && (cnt_q >= last);

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      cnt_q <= 8'h00;
    end else if (tick_i) begin
      cnt_q <= pulse_o ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule // ptm_prescale

/* File: design/ptm_timer.sv */
// Paired timer: two 16-bit timers, or one 32-bit timer/synchronous counter, behind Wishbone.
// Assumes a single 100 MHz clock; external clock pins are asynchronous and synchronised here.
// Contract
// - Run as two 16-bit timers or one 32-bit timer; no asynchronous counter.
// - Paired: first timer is low half, second timer is high half.
// - Paired: second control register ignored except its idle stop bit; first control and pins steer all.
// - Paired period match raises second timer's flag, enable and priority.
// - Paired period is second period (high) joined with first period (low).
// - Paired live count sits in both count registers, second holds high word.
// - Gate bit 6 accumulates while gate is high, internal clock only.
// - Pair bit 3 joins timers into one 32-bit timer.
// - Clock source bit 1 picks external pin rising edges or instruction clock.
// - Only the paired timer gives the converter trigger.
// - Each 16-bit count is offered as a time base to capture and compare.
// - Count matching period raises the timer's interrupt request.
// - Capture select picks which timer count is stored on capture.
`timescale 1ns/10ps
module ptm_timer (
  input wire logic clk_i, // 100 MHz instruction clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte enables
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic first_ext_clock_pin_i, // First timer clock or gate pin, async
  input wire logic second_ext_clock_pin_i, // Second timer clock or gate pin, async
  input wire logic idle_i, // Device in idle mode
  input wire logic capture_event_i, // Capture strobe from capture logic
  input wire logic capture_timer_select_i, // 1 = first count, 0 = second count
  output logic [15:0] capture_value_o, // Captured count
  output logic first_irq_o, // First timer interrupt request
  output logic second_irq_o, // Second timer interrupt request
  output logic [2:0] first_irq_priority_o, // First timer priority
  output logic [2:0] second_irq_priority_o, // Second timer priority
  output logic adc_trigger_o, // Converter trigger pulse
  output logic [15:0] first_count_o, // Time base from first timer
  output logic [15:0] second_count_o // Time base from second timer
);
  // ==========================================================================
  // Registers
  logic [15:0] ctrl_q [2];
  logic [15:0] cnt_q [2];
  logic [15:0] per_q [2];
  logic [1:0] flag_q;
  logic [15:0] irq_cfg_q;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] pin_prev_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic adc_q;
  logic [1:0] irq_q;
  logic [15:0] cap_q;

  logic pair;
  logic [15:0] ctrl_eff [2];
  logic [1:0] pin_lvl;
  logic [1:0] pin_rise;
  logic [1:0] run;
  logic [1:0] tick_in;
  logic [1:0] tick;
  logic [1:0] match16;
  logic match32;
  logic [1:0] set_flag;
  logic [1:0] cnt_wr;
  logic bus_req;
  logic bus_wr;
  logic [31:0] rdata_d;

  assign pair = ctrl_q[0][ptm_pkg::PAIR_BIT];

  // ==========================================================================
  // Pin synchronisers and per-channel clock selection
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          pin_prev_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= (g == 0) ? first_ext_clock_pin_i : second_ext_clock_pin_i;
          sync2_q[g] <= sync1_q[g];
          pin_prev_q[g] <= sync2_q[g];
        end
      end

      // Second timer takes the first timer's setup and pin when paired
      assign ctrl_eff[g] = (g == 1 && pair) ? ctrl_q[0] : ctrl_q[g];
      assign pin_lvl[g] = (g == 1 && pair) ? sync2_q[0] : sync2_q[g];
      assign pin_rise[g] = (g == 1 && pair) ? (sync2_q[0] && !pin_prev_q[0]) : (sync2_q[g] && !pin_prev_q[g]);

      // Paired idle stop honours both bits, so software must clear both
      assign run[g] = ctrl_eff[g][ptm_pkg::RUN_BIT] && !(idle_i && (ctrl_eff[g][ptm_pkg::IDLE_STOP_BIT] ||
        (pair && ctrl_q[1][ptm_pkg::IDLE_STOP_BIT])));

      always_comb begin
        if (ctrl_eff[g][ptm_pkg::CLK_SRC_BIT]) begin
          tick_in[g] = run[g] && pin_rise[g];
        end else if (ctrl_eff[g][ptm_pkg::GATE_BIT]) begin
          tick_in[g] = run[g] && pin_lvl[g];
        end else begin
          tick_in[g] = run[g];
        end
      end

      ptm_prescale u_pre (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(!run[g]),
        .tick_i(tick_in[g]),
        .sel_i(ctrl_eff[g][ptm_pkg::PRESCALE_LSB +: 2]),
        .pulse_o(tick[g])
      );

      assign match16[g] = (cnt_q[g] == per_q[g]);
    end
  endgenerate

  assign match32 = ({cnt_q[1], cnt_q[0]} == {per_q[1], per_q[0]});

  // ==========================================================================
  // Wishbone slave: one-cycle registered ack, unmapped reads return zero
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr = bus_req && wb_we_i;
  assign cnt_wr[0] = bus_wr && (wb_adr_i == ptm_pkg::FIRST_COUNT_OFS);
  assign cnt_wr[1] = bus_wr && (wb_adr_i == ptm_pkg::SECOND_COUNT_OFS);

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat, input logic [3:0] sel);
    merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (wb_adr_i)
      ptm_pkg::FIRST_CTRL_OFS: rdata_d[15:0] = ctrl_q[0];
      ptm_pkg::SECOND_CTRL_OFS: rdata_d[15:0] = ctrl_q[1];
      ptm_pkg::FIRST_COUNT_OFS: rdata_d[15:0] = cnt_q[0];
      ptm_pkg::SECOND_COUNT_OFS: rdata_d[15:0] = cnt_q[1];
      ptm_pkg::FIRST_PERIOD_OFS: rdata_d[15:0] = per_q[0];
      ptm_pkg::SECOND_PERIOD_OFS: rdata_d[15:0] = per_q[1];
      ptm_pkg::FLAG_OFS: rdata_d[1:0] = flag_q;
      ptm_pkg::IRQ_CFG_OFS: rdata_d[15:0] = irq_cfg_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      rdata_q <= (bus_req && !wb_we_i) ? rdata_d : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q[0] <= ptm_pkg::CTRL_RESET;
      ctrl_q[1] <= ptm_pkg::CTRL_RESET;
      per_q[0] <= ptm_pkg::PERIOD_RESET;
      per_q[1] <= ptm_pkg::PERIOD_RESET;
      irq_cfg_q <= ptm_pkg::IRQ_CFG_RESET;
    end else if (bus_wr) begin
      unique case (wb_adr_i)
        ptm_pkg::FIRST_CTRL_OFS: ctrl_q[0] <= merge16(ctrl_q[0], wb_dat_i, wb_sel_i) & ptm_pkg::FIRST_CTRL_MASK;
        ptm_pkg::SECOND_CTRL_OFS: ctrl_q[1] <= merge16(ctrl_q[1], wb_dat_i, wb_sel_i) & ptm_pkg::SECOND_CTRL_MASK;
        ptm_pkg::FIRST_PERIOD_OFS: per_q[0] <= merge16(per_q[0], wb_dat_i, wb_sel_i);
        ptm_pkg::SECOND_PERIOD_OFS: per_q[1] <= merge16(per_q[1], wb_dat_i, wb_sel_i);
        ptm_pkg::IRQ_CFG_OFS: irq_cfg_q <= merge16(irq_cfg_q, wb_dat_i, wb_sel_i) & ptm_pkg::IRQ_CFG_MASK;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Counters; a software write to a count takes priority over counting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q[0] <= ptm_pkg::COUNT_RESET;
      cnt_q[1] <= ptm_pkg::COUNT_RESET;
    end else begin
      if (pair) begin
        if (tick[0]) begin
          {cnt_q[1], cnt_q[0]} <= match32 ? 32'h0000_0000 : {cnt_q[1], cnt_q[0]} + 32'h0000_0001;
        end
      end else begin
        for (int i = 0; i < 2; i++) begin
          if (tick[i]) begin
            cnt_q[i] <= match16[i] ? 16'h0000 : cnt_q[i] + 16'h0001;
          end
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (cnt_wr[i]) begin
          cnt_q[i] <= merge16(cnt_q[i], wb_dat_i, wb_sel_i);
        end
      end
    end
  end

  // ==========================================================================
  // Flags, interrupt requests, converter trigger
  assign set_flag[0] = !pair && tick[0] && match16[0];
  assign set_flag[1] = pair ? (tick[0] && match32) : (tick[1] && match16[1]);

  // Set beats a same-cycle write-one-to-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 2'h0;
    end else begin
      flag_q <= (flag_q & ~((bus_wr && wb_adr_i == ptm_pkg::FLAG_OFS && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0))
        | set_flag;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 2'h0;
      adc_q <= 1'b0;
    end else begin
      irq_q <= flag_q & irq_cfg_q[1:0];
      adc_q <= pair && tick[0] && match32;
    end
  end

  // ==========================================================================
  // Capture of the selected time base
  // Raw count, so a capture on a tick edge stores the value before the step
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_q <= 16'h0000;
    end else if (capture_event_i) begin
      cap_q <= capture_timer_select_i ? cnt_q[0] : cnt_q[1];
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign first_irq_o = irq_q[0];
  assign second_irq_o = irq_q[1];
  assign first_irq_priority_o = irq_cfg_q[ptm_pkg::FIRST_PRIO_LSB +: 3];
  assign second_irq_priority_o = irq_cfg_q[ptm_pkg::SECOND_PRIO_LSB +: 3];
  assign adc_trigger_o = adc_q;
  assign first_count_o = cnt_q[0];
  assign second_count_o = cnt_q[1];
  assign capture_value_o = cap_q;

  // ==========================================================================
  // Assertions
  sequence wrap_seq;
    pair && tick[0] && match32 && cnt_wr == 2'h0;
  endsequence

  sequence wrapped_seq;
    cnt_q[0] == 16'h0000 && cnt_q[1] == 16'h0000 && flag_q[1] && !flag_q[0];
  endsequence

  period_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i) wrap_seq |=> wrapped_seq)
    else $error("paired count did not restart with flag on match");
  irq_route_a: assert property (@(posedge clk_i) disable iff (rst_i) wrap_seq ##1 irq_cfg_q[1] |=> second_irq_o)
    else $error("paired match did not reach second interrupt");
  pair_carry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pair && tick[0] && !match32 && cnt_q[0] == 16'hFFFF && cnt_wr == 2'h0 |=> cnt_q[1] == $past(cnt_q[1]) + 16'h0001
    && cnt_q[0] == 16'h0000)
    else $error("low word overflow did not carry into high word");
  adc_pair_only_a: assert property (@(posedge clk_i) disable iff (rst_i) adc_trigger_o |-> $past(pair))
    else $error("converter trigger outside paired mode");
  ctrl_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[0] & ~ptm_pkg::FIRST_CTRL_MASK) == 16'h0000 && (ctrl_q[1] & ~ptm_pkg::SECOND_CTRL_MASK) == 16'h0000)
    else $error("undefined control bit set");
  stop_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_q[0][ptm_pkg::RUN_BIT] && !cnt_wr[0] |=> $stable(cnt_q[0]))
    else $error("first count moved while stopped");
  idle_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    idle_i && ctrl_q[0][ptm_pkg::IDLE_STOP_BIT] && !cnt_wr[0] |=> $stable(cnt_q[0]))
    else $error("first count moved in idle with stop set");
  ext_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_in[0] && ctrl_q[0][ptm_pkg::CLK_SRC_BIT] |-> sync2_q[0] && !pin_prev_q[0])
    else $error("external clock tick without pin rising edge");
  second_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pair && !tick[0] && cnt_wr == 2'h0 |=> $stable(cnt_q[1]) && $stable(cnt_q[0]))
    else $error("paired count moved without first timer tick");
  capture_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    capture_event_i && capture_timer_select_i |=> capture_value_o == $past(cnt_q[0]))
    else $error("capture did not store first count");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  // ==========================================================================
  // Independent timers, flags, routing and bus answer
  sequence solo_wrap_seq;
    !pair && tick[1] && match16[1] && !cnt_wr[1];
  endsequence

  sequence solo_wrapped_seq;
    cnt_q[1] == 16'h0000 && flag_q[1];
  endsequence

  solo_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i) solo_wrap_seq |=> solo_wrapped_seq)
    else $error("second count did not restart with flag on match");
  solo_first_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pair && tick[0] && match16[0] && !cnt_wr[0] |=> cnt_q[0] == 16'h0000 && flag_q[0])
    else $error("first count did not restart with flag on match");
  second_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pair && !ctrl_q[1][ptm_pkg::RUN_BIT] && !cnt_wr[1] |=> $stable(cnt_q[1]))
    else $error("second count moved while stopped");
  idle_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pair && idle_i && ctrl_q[1][ptm_pkg::IDLE_STOP_BIT] && cnt_wr == 2'h0 |=> $stable(cnt_q[1]) && $stable(cnt_q[0]))
    else $error("paired count moved in idle with second stop set");
  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    set_flag != 2'h0 |=> (flag_q & $past(set_flag)) == $past(set_flag))
    else $error("period match flag was lost");
  first_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_q[0] && irq_cfg_q[0] |=> first_irq_o)
    else $error("enabled first flag did not raise interrupt");
  second_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_q[1] && irq_cfg_q[1] |=> second_irq_o)
    else $error("enabled second flag did not raise interrupt");
  gate_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_in[0] && !ctrl_q[0][ptm_pkg::CLK_SRC_BIT] && ctrl_q[0][ptm_pkg::GATE_BIT] |-> sync2_q[0])
    else $error("gated count advanced with gate low");
  adc_match_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pair && tick[0] && match32 |=> adc_trigger_o)
    else $error("paired match gave no converter trigger");
  capture_other_a: assert property (@(posedge clk_i) disable iff (rst_i)
    capture_event_i && !capture_timer_select_i |=> capture_value_o == $past(cnt_q[1]))
    else $error("capture did not store second count");
  ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req |=> wb_ack_o)
    else $error("bus request not acknowledged in the next cycle");
endmodule // ptm_timer

/* File: bench/test_ptm_timer.sv */
// Self-checking bench for the paired 16/32-bit timer.
// Assumes ptm_pkg and ptm_timer are compiled first; drives Wishbone and pins itself.
`timescale 1ns/10ps
module test_ptm_timer;
  logic clk_i, rst_i, cyc, stb, we, ext1, ext2, idle, cap_ev, cap_sel;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, wb_dat_o;
  logic wb_ack_o, irq1, irq2, adc;
  logic [2:0] pri1, pri2;
  logic [15:0] cap_val, cnt1, cnt2, q;
  int n_fail, n_tests, n;
  logic adc_seen;
  localparam logic [15:0] RUN = 16'h0001 << ptm_pkg::RUN_BIT;
  localparam logic [15:0] IDL = 16'h0001 << ptm_pkg::IDLE_STOP_BIT;
  localparam logic [15:0] GATE = 16'h0001 << ptm_pkg::GATE_BIT;
  localparam logic [15:0] PAIR = 16'h0001 << ptm_pkg::PAIR_BIT;
  localparam logic [15:0] EXT = 16'h0001 << ptm_pkg::CLK_SRC_BIT;

  ptm_timer ptm_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .first_ext_clock_pin_i(ext1), .second_ext_clock_pin_i(ext2), .idle_i(idle),
    .capture_event_i(cap_ev), .capture_timer_select_i(cap_sel), .capture_value_o(cap_val),
    .first_irq_o(irq1), .second_irq_o(irq2), .first_irq_priority_o(pri1), .second_irq_priority_o(pri2),
    .adc_trigger_o(adc), .first_count_o(cnt1), .second_count_o(cnt2));

  // ==========================================================================
  // Clock, watchdog, converter trigger monitor
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    tally_and_finish();
  end
  always @(negedge clk_i) if (adc === 1'b1) adc_seen = 1'b1;

  // ==========================================================================
  // Bus and compare tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; dat_w <= {16'h0000, d};
    // Ack and read data are taken at the rising edge that samples ack high
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    r = wb_dat_o[15:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000, q);
    chk(what, exp, q);
  endtask
  task automatic cyc_n(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset_and_mask();
    logic [7:0] ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    logic [15:0] rv [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 9; i++) rdchk("reset value", ofs[i], rv[i]);
    wr(ptm_pkg::FIRST_CTRL_OFS, 16'hFFFF);
    rdchk("first control mask", ptm_pkg::FIRST_CTRL_OFS, ptm_pkg::FIRST_CTRL_MASK);
    wr(ptm_pkg::FIRST_CTRL_OFS, 16'h0000);
    wr(ptm_pkg::SECOND_CTRL_OFS, 16'hFFFF);
    rdchk("second control mask", ptm_pkg::SECOND_CTRL_OFS, ptm_pkg::SECOND_CTRL_MASK);
    wr(ptm_pkg::SECOND_CTRL_OFS, 16'h0000);
  endtask

  task automatic t_prescale();
    int div [4] = '{1, 8, 64, 256};
    for (int c = 0; c < 4; c++) begin
      wr(ptm_pkg::FIRST_PERIOD_OFS, 16'hFFFF);
      wr(ptm_pkg::FIRST_CTRL_OFS, RUN | (16'(c) << ptm_pkg::PRESCALE_LSB));
      q = cnt1;
      @(negedge clk_i);
      while (cnt1 === q) @(negedge clk_i);
      q = cnt1;
      n = 0;
      while (cnt1 === q && n < 400) begin
        @(negedge clk_i);
        n++;
      end
      chk("prescale ticks", 16'(div[c]), 16'(n));
    end
    wr(ptm_pkg::FIRST_CTRL_OFS, 16'h0000);
    q = cnt1;
    cyc_n(20);
    chk("stopped count", q, cnt1);
  endtask

  task automatic t_match16();
    wr(ptm_pkg::FIRST_COUNT_OFS, 16'h0000);
    wr(ptm_pkg::FIRST_PERIOD_OFS, 16'h0003);
    wr(ptm_pkg::IRQ_CFG_OFS, 16'h0031);
    chk("first priority", 16'h0003, {13'h0000, pri1});
    adc_seen = 1'b0;
    wr(ptm_pkg::FIRST_CTRL_OFS, RUN);
    while (cnt1 !== 16'h0003) @(negedge clk_i);
    cyc_n(1);
    chk("count after match", 16'h0000, cnt1);
    cyc_n(4);
    chk("count one period later", 16'h0000, cnt1);
    cyc_n(1);
    chk("first irq", 16'h0001, {15'h0000, irq1});
    wr(ptm_pkg::FIRST_CTRL_OFS, 16'h0000);
    rdchk("flags 16-bit", ptm_pkg::FLAG_OFS, 16'h0001);
    chk("no converter trigger", 16'h0000, {15'h0000, adc_seen});
    wr(ptm_pkg::FLAG_OFS, 16'h0003);
    rdchk("flags cleared", ptm_pkg::FLAG_OFS, 16'h0000);
  endtask

  task automatic t_second16();
    wr(ptm_pkg::SECOND_COUNT_OFS, 16'h0000);
    wr(ptm_pkg::SECOND_PERIOD_OFS, 16'h0002);
    wr(ptm_pkg::IRQ_CFG_OFS, 16'h0502);
    chk("second priority", 16'h0005, {13'h0000, pri2});
    q = cnt1;
    adc_seen = 1'b0;
    wr(ptm_pkg::SECOND_CTRL_OFS, RUN);
    while (cnt2 !== 16'h0002) @(negedge clk_i);
    cyc_n(1);
    chk("second count after match", 16'h0000, cnt2);
    cyc_n(1);
    chk("second irq 16-bit", 16'h0001, {15'h0000, irq2});
    chk("first count independent", q, cnt1);
    wr(ptm_pkg::SECOND_CTRL_OFS, 16'h0000);
    rdchk("flags second 16-bit", ptm_pkg::FLAG_OFS, 16'h0002);
    chk("no trigger from second", 16'h0000, {15'h0000, adc_seen});
    wr(ptm_pkg::FLAG_OFS, 16'h0003);
  endtask

  task automatic t_pair();
    wr(ptm_pkg::FIRST_CTRL_OFS, PAIR);
    // Slow prescale and run in the second control must have no effect
    wr(ptm_pkg::SECOND_CTRL_OFS, RUN | 16'h0030);
    wr(ptm_pkg::FIRST_COUNT_OFS, 16'hFFFE);
    wr(ptm_pkg::SECOND_COUNT_OFS, 16'h0000);
    wr(ptm_pkg::FIRST_PERIOD_OFS, 16'h0001);
    wr(ptm_pkg::SECOND_PERIOD_OFS, 16'h0001);
    wr(ptm_pkg::IRQ_CFG_OFS, 16'h0002);
    adc_seen = 1'b0;
    wr(ptm_pkg::FIRST_CTRL_OFS, PAIR | RUN);
    while (cnt1 !== 16'hFFFF) @(negedge clk_i);
    cyc_n(1);
    chk("carry upper", 16'h0001, cnt2);
    chk("carry lower", 16'h0000, cnt1);
    cyc_n(2);
    chk("paired match upper", 16'h0000, cnt2);
    chk("paired match lower", 16'h0000, cnt1);
    cyc_n(1);
    chk("second irq", 16'h0001, {15'h0000, irq2});
    chk("converter trigger", 16'h0001, {15'h0000, adc_seen});
    wr(ptm_pkg::FIRST_CTRL_OFS, PAIR);
    rdchk("flags paired", ptm_pkg::FLAG_OFS, 16'h0002);
    wr(ptm_pkg::FLAG_OFS, 16'h0003);
    wr(ptm_pkg::FIRST_CTRL_OFS, 16'h0000);
    wr(ptm_pkg::SECOND_CTRL_OFS, 16'h0000);
  endtask

  task automatic t_idle();
    wr(ptm_pkg::FIRST_PERIOD_OFS, 16'hFFFF);
    wr(ptm_pkg::FIRST_COUNT_OFS, 16'h0000);
    @(posedge clk_i);
    idle <= 1'b1;
    wr(ptm_pkg::FIRST_CTRL_OFS, RUN | IDL);
    q = cnt1;
    cyc_n(10);
    chk("idle stop holds", q, cnt1);
    wr(ptm_pkg::FIRST_CTRL_OFS, RUN);
    cyc_n(2);
    q = cnt1;
    cyc_n(10);
    chk("idle keeps counting", q + 16'h000A, cnt1);
    wr(ptm_pkg::SECOND_CTRL_OFS, IDL);
    wr(ptm_pkg::FIRST_CTRL_OFS, PAIR | RUN);
    q = cnt1;
    cyc_n(10);
    chk("paired idle stop holds", q, cnt1);
    wr(ptm_pkg::SECOND_CTRL_OFS, 16'h0000);
    cyc_n(2);
    q = cnt1;
    cyc_n(10);
    chk("paired idle keeps counting", q + 16'h000A, cnt1);
    wr(ptm_pkg::FIRST_CTRL_OFS, 16'h0000);
    @(posedge clk_i);
    idle <= 1'b0;
  endtask

  task automatic t_ext_gate();
    wr(ptm_pkg::FIRST_COUNT_OFS, 16'h0000);
    wr(ptm_pkg::FIRST_CTRL_OFS, RUN | EXT);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      ext1 <= 1'b1;
      repeat (3) @(posedge clk_i);
      ext1 <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    cyc_n(6);
    chk("external edges", 16'h0005, cnt1);
    wr(ptm_pkg::FIRST_CTRL_OFS, 16'h0000);
    wr(ptm_pkg::FIRST_COUNT_OFS, 16'h0000);
    wr(ptm_pkg::FIRST_CTRL_OFS, RUN | GATE);
    cyc_n(8);
    chk("gate low holds", 16'h0000, cnt1);
    @(posedge clk_i);
    ext1 <= 1'b1;
    repeat (10) @(posedge clk_i);
    ext1 <= 1'b0;
    cyc_n(8);
    chk("gated accumulation", 16'h000A, cnt1);
    wr(ptm_pkg::FIRST_CTRL_OFS, 16'h0000);
  endtask

  task automatic t_capture();
    wr(ptm_pkg::FIRST_COUNT_OFS, 16'h1234);
    wr(ptm_pkg::SECOND_COUNT_OFS, 16'hABCD);
    cyc_n(1);
    chk("first time base", 16'h1234, cnt1);
    chk("second time base", 16'hABCD, cnt2);
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk_i);
      cap_ev <= 1'b1;
      cap_sel <= s[0];
      @(posedge clk_i);
      cap_ev <= 1'b0;
      cyc_n(2);
      chk("captured count", s ? 16'h1234 : 16'hABCD, cap_val);
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    n_fail = 0;
    n_tests = 0;
    adc_seen = 1'b0;
    rst_i = 1'b1;
    {cyc, stb, we, ext1, ext2, idle, cap_ev, cap_sel} = 8'h00;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0000_0000;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_and_mask();
    t_prescale();
    t_match16();
    t_second16();
    t_pair();
    t_idle();
    t_ext_gate();
    t_capture();
    tally_and_finish();
  end
endmodule // test_ptm_timer
